// [verilog/iad_map.svh]
// Purpose: Register offsets, field positions, reset values and sizes of the alarm/DIO block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef IAD_MAP_SVH
`define IAD_MAP_SVH

// Sizes
`define IAD_NUM_IN 4
`define IAD_NUM_DOUT 5
`define IAD_NUM_DIN 6

// Global registers
`define IAD_CTRL_OFS 8'h00
`define IAD_MANUAL_OFS 8'h04
`define IAD_DIN_OFS 8'h08
`define IAD_STATUS_OFS 8'h0c

// Per-input registers: base plus index times stride
`define IAD_IN_BASE_SLOT 4'h2
`define IAD_IN_CFG_FLD 2'h0
`define IAD_IN_LOW_FLD 2'h1
`define IAD_IN_HIGH_FLD 2'h2

// Control register fields
`define IAD_CTRL_MODE_LSB 0
`define IAD_CTRL_BEEPOFF_BIT 2
`define IAD_CTRL_ARST_BIT 3

// Input config fields
`define IAD_CFG_EN_BIT 0
`define IAD_CFG_LATCH_BIT 1
`define IAD_CFG_RELAY_BIT 2
`define IAD_CFG_SRC_LSB 3

// Status register fields
`define IAD_ST_ALO_LSB 0
`define IAD_ST_AHI_LSB 4
`define IAD_ST_IND_EN_BIT 8
`define IAD_ST_IND_ALM_BIT 9
`define IAD_ST_RLY_HI_BIT 10
`define IAD_ST_RLY_LO_BIT 11
`define IAD_ST_BEEP_BIT 12
`define IAD_ST_DOUT_LSB 16

// Reset values
`define IAD_MANUAL_RST 5'h00
`define IAD_LOW_RST 32'sh0000_0000
`define IAD_HIGH_RST 32'sh0000_03e8

`endif

// [verilog/iad_pkg.sv]
// Purpose: Types shared by the alarm and digital I/O block
// Assumes: Readings arrive as signed fixed-point words, each source in its own unit
// Notes: Constants live in iad_map.svh
package iad_pkg;

  // Digital output mode, off is the reset value
  typedef enum logic [1:0] {
    IAD_DOUT_OFF,
    IAD_DOUT_ALARM,
    IAD_DOUT_MANUAL,
    IAD_DOUT_SCANNER
  } iad_dout_mode_t;

  // Alarm data source, Kelvin is the reset value
  typedef enum logic [1:0] {
    IAD_SRC_KELVIN,
    IAD_SRC_CELSIUS,
    IAD_SRC_SENSOR,
    IAD_SRC_LINEAR
  } iad_src_t;

  // One input's readings, all four sources side by side
  typedef struct packed {
    logic signed [31:0] kelvin;
    logic signed [31:0] celsius;
    logic signed [31:0] sensor;
    logic signed [31:0] linear;
  } iad_reading_t;

  // Per-input alarm settings
  typedef struct packed {
    iad_src_t src;
    logic relay;
    logic latch;
    logic enable;
  } iad_cfg_t;

endpackage

// [verilog/iad_alarm_io.sv]
// Purpose: Input high/low alarms, indicators, beeper, relays and the digital I/O port
// Assumes: Single clock pclk at 10 MHz, APB register access, readings synchronous to pclk
// Notes: Inputs 0 and 1 are A and B; 2 and 3 are optional and gated by opt_installed
//
// Decided for this implementation: the register offsets and the APB slave port.
`include "iad_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iad_alarm_io (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement path
  input wire iad_pkg::iad_reading_t [`IAD_NUM_IN-1:0] reading,
  input wire logic [`IAD_NUM_IN-1:0] reading_valid,
  input wire logic [1:0] opt_installed,
  input wire logic [4:0] scan_chan,
  // Digital I/O port
  input wire logic [`IAD_NUM_DIN-1:0] din,
  output logic [`IAD_NUM_DOUT-1:0] dout,
  // Annunciators, beeper, relays
  output logic ind_enabled,
  output logic ind_alarming,
  output logic beeper,
  output logic relay_hi,
  output logic relay_lo
);

  localparam int NIN = `IAD_NUM_IN;

  // Settings
  iad_pkg::iad_dout_mode_t mode_q;
  logic beep_off_q;
  logic [`IAD_NUM_DOUT-1:0] manual_q;
  iad_pkg::iad_cfg_t cfg_q [NIN];
  logic signed [31:0] low_q [NIN];
  logic signed [31:0] high_q [NIN];

  // State
  logic [`IAD_NUM_DIN-1:0] din_q;
  logic [NIN-1:0] cond_hi_q, cond_lo_q, cond_hi_d, cond_lo_d;
  logic [NIN-1:0] alm_hi_q, alm_lo_q, alm_hi_d, alm_lo_d;
  logic [`IAD_NUM_DOUT-1:0] dout_d;
  logic [NIN-1:0] installed, active, relay_vec;
  logic alarm_rst, ind_en_d, ind_alm_d;

  // Bus decode
  logic wr_en, rd_setup, in_hit, rd_ok;
  logic [1:0] in_idx, in_fld;
  logic [31:0] rd_data;

  // Picks the configured source and compares strictly; returns {high, low}
  function automatic logic [1:0] eval_cond(input iad_pkg::iad_reading_t r,
                                           input iad_pkg::iad_src_t src,
                                           input logic signed [31:0] lo,
                                           input logic signed [31:0] hi);
    logic signed [31:0] v;
    v = r.kelvin;
    case (src)
      iad_pkg::IAD_SRC_KELVIN: v = r.kelvin;
      iad_pkg::IAD_SRC_CELSIUS: v = r.celsius;
      iad_pkg::IAD_SRC_SENSOR: v = r.sensor;
      iad_pkg::IAD_SRC_LINEAR: v = r.linear;
      default: v = r.kelvin;
    endcase
    return {v > hi, v < lo};
  endfunction

  // Per-input window: slot in paddr[7:4], field in paddr[3:2]
  function automatic logic in_window(input logic [7:0] a);
    logic [3:0] slot;
    slot = a[7:4] - `IAD_IN_BASE_SLOT;
    return (a[7:4] >= `IAD_IN_BASE_SLOT) && (slot < 4'(NIN)) &&
           (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  assign installed = {opt_installed, 2'b11};
  assign wr_en = ce & psel & penable & pwrite;
  assign rd_setup = ce & psel & ~penable;
  assign in_hit = in_window(paddr);
  assign in_idx = 2'(paddr[7:4] - `IAD_IN_BASE_SLOT);
  assign in_fld = paddr[3:2];
  assign alarm_rst = wr_en & (paddr == `IAD_CTRL_OFS) & pwdata[`IAD_CTRL_ARST_BIT];

  // Zero-wait slave; a frozen block holds the bus off rather than lose a write
  assign pready = ce;
  assign pslverr = psel & penable & ~rd_ok;

  // Global settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= iad_pkg::IAD_DOUT_OFF;
      beep_off_q <= 1'b0;
      manual_q <= `IAD_MANUAL_RST;
    end else if (wr_en && paddr == `IAD_CTRL_OFS) begin
      mode_q <= iad_pkg::iad_dout_mode_t'(pwdata[`IAD_CTRL_MODE_LSB +: 2]);
      beep_off_q <= pwdata[`IAD_CTRL_BEEPOFF_BIT];
    end else if (wr_en && paddr == `IAD_MANUAL_OFS) begin
      manual_q <= pwdata[`IAD_NUM_DOUT-1:0];
    end
  end

  // Per-input settings; a new source brings the thresholds back to default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NIN; i++) begin
        cfg_q[i] <= '0;
        low_q[i] <= `IAD_LOW_RST;
        high_q[i] <= `IAD_HIGH_RST;
      end
    end else if (wr_en && in_hit) begin
      case (in_fld)
        `IAD_IN_CFG_FLD: begin
          cfg_q[in_idx].enable <= pwdata[`IAD_CFG_EN_BIT];
          cfg_q[in_idx].latch <= pwdata[`IAD_CFG_LATCH_BIT];
          cfg_q[in_idx].relay <= pwdata[`IAD_CFG_RELAY_BIT];
          cfg_q[in_idx].src <= iad_pkg::iad_src_t'(pwdata[`IAD_CFG_SRC_LSB +: 2]);
          if (pwdata[`IAD_CFG_SRC_LSB +: 2] != cfg_q[in_idx].src) begin
            low_q[in_idx] <= `IAD_LOW_RST;
            high_q[in_idx] <= `IAD_HIGH_RST;
          end
        end
        `IAD_IN_LOW_FLD: low_q[in_idx] <= pwdata;
        `IAD_IN_HIGH_FLD: high_q[in_idx] <= pwdata;
        default: ;
      endcase
    end
  end

  // Digital inputs sampled every enabled cycle regardless of mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q <= '0;
    end else if (ce) begin
      din_q <= din;
    end
  end

  // Alarm evaluation; a reading strobe takes effect at the very next edge
  always_comb begin
    logic [1:0] c;
    c = 2'b00;
    for (int i = 0; i < NIN; i++) begin
      active[i] = cfg_q[i].enable & installed[i];
      relay_vec[i] = cfg_q[i].relay;
      c = eval_cond(reading[i], cfg_q[i].src, low_q[i], high_q[i]);
      cond_hi_d[i] = active[i] & (reading_valid[i] ? c[1] : cond_hi_q[i]);
      cond_lo_d[i] = active[i] & (reading_valid[i] ? c[0] : cond_lo_q[i]);
      // Latch holds until reset; a live condition always wins over reset
      alm_hi_d[i] = active[i] & (cond_hi_d[i] |
                    (cfg_q[i].latch & alm_hi_q[i] & ~alarm_rst));
      alm_lo_d[i] = active[i] & (cond_lo_d[i] |
                    (cfg_q[i].latch & alm_lo_q[i] & ~alarm_rst));
    end
  end

  // Condition and alarm state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_hi_q <= '0;
      cond_lo_q <= '0;
      alm_hi_q <= '0;
      alm_lo_q <= '0;
    end else if (ce) begin
      cond_hi_q <= cond_hi_d;
      cond_lo_q <= cond_lo_d;
      alm_hi_q <= alm_hi_d;
      alm_lo_q <= alm_lo_d;
    end
  end

  // Output port mode select
  always_comb begin
    case (mode_q)
      iad_pkg::IAD_DOUT_OFF: dout_d = '0;
      iad_pkg::IAD_DOUT_ALARM: dout_d = {|(alm_hi_d[NIN-1:2] | alm_lo_d[NIN-1:2]),
                                         alm_hi_d[1], alm_lo_d[1],
                                         alm_hi_d[0], alm_lo_d[0]};
      iad_pkg::IAD_DOUT_MANUAL: dout_d = manual_q;
      iad_pkg::IAD_DOUT_SCANNER: dout_d = scan_chan;
      default: dout_d = '0;
    endcase
  end

  assign ind_en_d = |active;
  assign ind_alm_d = |(alm_hi_d | alm_lo_d);

  // Registered outputs, in step with the alarm state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= '0;
      ind_enabled <= 1'b0;
      ind_alarming <= 1'b0;
      beeper <= 1'b0;
      relay_hi <= 1'b0;
      relay_lo <= 1'b0;
    end else if (ce) begin
      dout <= dout_d;
      ind_enabled <= ind_en_d;
      ind_alarming <= ind_alm_d;
      beeper <= ind_alm_d & ~beep_off_q;
      relay_hi <= |(alm_hi_d & relay_vec);
      relay_lo <= |(alm_lo_d & relay_vec);
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (paddr == `IAD_CTRL_OFS) begin
      rd_data[`IAD_CTRL_MODE_LSB +: 2] = mode_q;
      rd_data[`IAD_CTRL_BEEPOFF_BIT] = beep_off_q;
    end else if (paddr == `IAD_MANUAL_OFS) begin
      rd_data[`IAD_NUM_DOUT-1:0] = manual_q;
    end else if (paddr == `IAD_DIN_OFS) begin
      rd_data[`IAD_NUM_DIN-1:0] = din_q;
    end else if (paddr == `IAD_STATUS_OFS) begin
      rd_data[`IAD_ST_ALO_LSB +: NIN] = alm_lo_q;
      rd_data[`IAD_ST_AHI_LSB +: NIN] = alm_hi_q;
      rd_data[`IAD_ST_IND_EN_BIT] = ind_enabled;
      rd_data[`IAD_ST_IND_ALM_BIT] = ind_alarming;
      rd_data[`IAD_ST_RLY_HI_BIT] = relay_hi;
      rd_data[`IAD_ST_RLY_LO_BIT] = relay_lo;
      rd_data[`IAD_ST_BEEP_BIT] = beeper;
      rd_data[`IAD_ST_DOUT_LSB +: `IAD_NUM_DOUT] = dout;
    end else if (in_hit) begin
      case (in_fld)
        `IAD_IN_CFG_FLD: begin
          rd_data[`IAD_CFG_EN_BIT] = cfg_q[in_idx].enable;
          rd_data[`IAD_CFG_LATCH_BIT] = cfg_q[in_idx].latch;
          rd_data[`IAD_CFG_RELAY_BIT] = cfg_q[in_idx].relay;
          rd_data[`IAD_CFG_SRC_LSB +: 2] = cfg_q[in_idx].src;
        end
        `IAD_IN_LOW_FLD: rd_data = low_q[in_idx];
        `IAD_IN_HIGH_FLD: rd_data = high_q[in_idx];
        default: rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read data captured in the setup cycle so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hi0_cond;
    ce && active[0] && reading_valid[0] &&
    cfg_q[0].src == iad_pkg::IAD_SRC_KELVIN && reading[0].kelvin > high_q[0];
  endsequence

  sequence s_lo0_cond;
    ce && active[0] && reading_valid[0] &&
    cfg_q[0].src == iad_pkg::IAD_SRC_KELVIN && reading[0].kelvin < low_q[0];
  endsequence

  // Latch checks watch input B; the logic is per index, so one input stands for all
  sequence s_hi1_latched;
    ce && active[1] && cfg_q[1].latch && alm_hi_q[1];
  endsequence

  sequence s_lo1_latched;
    ce && active[1] && cfg_q[1].latch && alm_lo_q[1];
  endsequence

  sequence s_lo1_cond;
    ce && active[1] && reading_valid[1] &&
    cfg_q[1].src == iad_pkg::IAD_SRC_SENSOR && reading[1].sensor < low_q[1];
  endsequence

  // Output port modes
  off_zero_a: assert property (ce && mode_q == iad_pkg::IAD_DOUT_OFF |=> dout == 5'h00)
    else $error("dout not zero in off mode");
  manual_pat_a: assert property (ce && mode_q == iad_pkg::IAD_DOUT_MANUAL
    |=> dout == $past(manual_q)) else $error("dout differs from manual pattern");
  alarm_map_a: assert property (ce && mode_q == iad_pkg::IAD_DOUT_ALARM
    |=> dout[3:0] == {alm_hi_q[1], alm_lo_q[1], alm_hi_q[0], alm_lo_q[0]})
    else $error("alarm mapping on dout wrong");
  disabled_quiet_a: assert property (ce && !cfg_q[0].enable
    |=> !alm_hi_q[0] && !alm_lo_q[0]) else $error("disabled input raised an alarm");
  // Comparisons, latching and alarm reset
  high_cmp_a: assert property (s_hi0_cond |=> alm_hi_q[0] && cond_hi_q[0])
    else $error("high alarm missed one cycle after strobe");
  low_cmp_a: assert property (s_lo0_cond |=> alm_lo_q[0] && cond_lo_q[0])
    else $error("low alarm missed one cycle after strobe");
  sensor_low_a: assert property (s_lo1_cond |=> alm_lo_q[1] && cond_lo_q[1])
    else $error("sensor-source low alarm missed");
  latch_hold_a: assert property (s_hi1_latched and (!alarm_rst) |=> alm_hi_q[1])
    else $error("latched alarm dropped without reset");
  nolatch_drop_a: assert property (ce && !cfg_q[0].latch && !reading_valid[0] &&
    !cond_hi_q[0] |=> !alm_hi_q[0]) else $error("non-latching alarm did not drop");
  reset_keep_a: assert property (s_lo1_latched and (alarm_rst && cond_lo_q[1] &&
    !reading_valid[1]) |=> alm_lo_q[1]) else $error("reset cleared live alarm");
  reset_clear_a: assert property (s_hi1_latched and (alarm_rst && !cond_hi_q[1] &&
    !reading_valid[1]) |=> !alm_hi_q[1]) else $error("reset failed to clear alarm");
  beeper_gate_a: assert property (ce |=> beeper == (ind_alarming && !$past(beep_off_q)))
    else $error("beeper disagrees with alarm state");
  relay_route_a: assert property (ce |=> relay_hi == |(alm_hi_q & $past(relay_vec)))
    else $error("high relay disagrees with routed alarms");

  // Scanner lines, the optional-input line and the live digital inputs
  scan_pass_a: assert property (ce && mode_q == iad_pkg::IAD_DOUT_SCANNER
    |=> dout == $past(scan_chan)) else $error("dout differs from scan channel");
  opt_line_a: assert property (ce && mode_q == iad_pkg::IAD_DOUT_ALARM
    |=> dout[4] == |{alm_hi_q[3:2], alm_lo_q[3:2]})
    else $error("optional alarm line wrong");
  absent_quiet_a: assert property (ce && !installed[3]
    |=> !alm_hi_q[3] && !alm_lo_q[3]) else $error("absent input raised an alarm");
  din_live_a: assert property (ce |=> din_q == $past(din))
    else $error("digital inputs not sampled");

  // Indicators, beeper and relays follow the alarm state of the same edge
  ind_alarm_a: assert property (ce |=> ind_alarming == |{alm_hi_q, alm_lo_q})
    else $error("alarming indicator disagrees with alarms");
  ind_enable_a: assert property (ce && cfg_q[0].enable |=> ind_enabled)
    else $error("enabled indicator missing");
  beep_quiet_a: assert property (ce && beep_off_q |=> !beeper)
    else $error("beeper sounded while disabled");
  relay_low_a: assert property (ce
    |=> relay_lo == |(alm_lo_q & $past(relay_vec)))
    else $error("low relay disagrees with routed alarms");
  relay_none_a: assert property (ce && relay_vec == '0 |=> !relay_hi && !relay_lo)
    else $error("relay moved with nothing routed");

  // A low clock enable freezes alarms and outputs; a strobe in that cycle is lost
  frozen_hold_a: assert property (!ce
    |=> $stable(alm_hi_q) && $stable(alm_lo_q) && $stable(dout))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// [verif/iad_dio_partner.sv]
// Purpose: External equipment wired to the digital input lines
// Assumes: The inputs carry pull-ups, so lines that nobody drives read high
// Notes: The bench decides when the equipment drives and with which pattern
`timescale 1ns/1ps
`default_nettype none

module iad_dio_partner (
  // Bench control
  input wire logic drive,
  input wire logic [5:0] pattern,
  // Port lines
  output logic [5:0] din
);
  // Released lines float to the pull-up level, never to the last value
  assign din = drive ? pattern : 6'h3f;
endmodule

`default_nettype wire

// [verif/iad_alarm_io_test.sv]
// Purpose: Self-checking bench for the alarm and digital I/O block
// Assumes: ce high during every APB access, so each ends in its first access cycle
// Notes: Expected read words queue up; a monitor compares them as reads finish
`include "iad_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iad_alarm_io_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ind_enabled, ind_alarming, beeper, relay_hi, relay_lo;
  iad_pkg::iad_reading_t [3:0] reading = '0;
  logic [3:0] reading_valid = 4'h0;
  logic [1:0] opt_installed = 2'h0;
  logic [4:0] scan_chan = 5'h00;
  logic [5:0] din, pattern = 6'h00;
  logic [4:0] dout;
  logic drive = 1'b0;
  logic ce = 1'b1;
  // Reference state of the bench
  logic [3:0] en = 4'h0, lat = 4'h0, rly = 4'h0, chi = 4'h0, clo = 4'h0, ahi = 4'h0, alo = 4'h0;
  logic [1:0] src[4] = '{default: 2'h0};
  logic signed [31:0] lot[4] = '{default: 0};
  logic signed [31:0] hit[4] = '{default: 1000};
  logic [1:0] mode = 2'h0;
  logic beep_off = 1'b0;
  logic [4:0] man = 5'h00, sc = 5'h00;
  logic [5:0] p;
  int t, mismatches = 0, checked = 0;
  int vals[4] = '{1001, 1000, -1, 0};
  logic [32:0] exp_q[$];
  string nm_q[$];

  // 100 ns clock
  always #50 pclk = ~pclk;

  iad_alarm_io dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reading(reading), .reading_valid(reading_valid),
    .opt_installed(opt_installed), .scan_chan(scan_chan), .din(din), .dout(dout),
    .ind_enabled(ind_enabled), .ind_alarming(ind_alarming), .beeper(beeper),
    .relay_hi(relay_hi), .relay_lo(relay_lo));

  iad_dio_partner partner (.drive(drive), .pattern(pattern), .din(din));

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_word(input string nm, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected status word; off mode yields zero lines
  function automatic logic [31:0] st_exp();
    logic [4:0] d;
    d = 5'h00;
    if (mode == 2'h1) begin
      d = {|{ahi[3:2], alo[3:2]}, ahi[1], alo[1], ahi[0], alo[0]};
    end else if (mode == 2'h2) begin
      d = man;
    end else if (mode == 2'h3) begin
      d = sc;
    end
    return {11'h000, d, 3'h0, !beep_off && |{ahi, alo}, |(alo & rly), |(ahi & rly),
      |{ahi, alo}, |(en & {opt_installed, 2'b11}), ahi, alo};
  endfunction

  // APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm,
      input logic [32:0] e);
    int n;
    if (!w) begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
    end
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, "", 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input string nm, input logic [32:0] e);
    apb(1'b0, a, 32'h0, nm, e);
  endtask

  task automatic rs();
    rd(`IAD_STATUS_OFS, "status", {1'b0, st_exp()});
  endtask

  function automatic logic [7:0] ad(input int i, input int f);
    return 8'(32 + 16 * i + 4 * f);
  endfunction

  // Control write; alarm reset keeps only alarms whose condition remains
  task automatic ctl(input logic [1:0] m, input logic b, input logic a);
    mode = m;
    beep_off = b;
    if (a) begin
      ahi &= chi;
      alo &= clo;
    end
    wr(`IAD_CTRL_OFS, {28'h0, a, b, m});
  endtask

  // Input settings; a new source restores thresholds, disabling drops alarms
  task automatic cfg(input int i, input logic e, input logic l, input logic r, input logic [1:0] s);
    if (s != src[i]) begin
      lot[i] = 0;
      hit[i] = 1000;
    end
    src[i] = s;
    en[i] = e;
    lat[i] = l;
    rly[i] = r;
    if (!e) begin
      {chi[i], clo[i], ahi[i], alo[i]} = 4'h0;
    end
    wr(ad(i, 0), {27'h0, s, r, l, e});
  endtask

  // One reading; unselected sources sit in range so a wrong pick shows
  task automatic strobe(input int i, input logic signed [31:0] v);
    iad_pkg::iad_reading_t r;
    r = {4{32'sd500}};
    if (src[i] == 2'h0) r.kelvin = v;
    else if (src[i] == 2'h1) r.celsius = v;
    else if (src[i] == 2'h2) r.sensor = v;
    else r.linear = v;
    @(posedge pclk);
    reading[i] <= r;
    reading_valid[i] <= 1'b1;
    @(posedge pclk);
    reading_valid[i] <= 1'b0;
    if (en[i] && (i < 2 || opt_installed[i % 2])) begin
      chi[i] = v > hit[i];
      clo[i] = v < lot[i];
      ahi[i] = chi[i] | (lat[i] & ahi[i]);
      alo[i] = clo[i] | (lat[i] & alo[i]);
    end
  endtask

  // Monitor: each finished read is matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check_word(nm_q.pop_front(), exp_q.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    void'($urandom(22912));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped field
    rd(`IAD_CTRL_OFS, "ctrl", 33'h0);
    rd(`IAD_MANUAL_OFS, "manual", 33'h0);
    for (int i = 0; i < 4; i++) begin
      rd(ad(i, 0), "cfg", 33'h0);
      rd(ad(i, 1), "low", 33'h0);
      rd(ad(i, 2), "high", 33'h3e8);
    end
    rd(ad(0, 3), "unmapped", {1'b1, 32'h0});
    rs();
    // Inputs in every mode, driven and released; every output mode
    for (int m = 0; m < 4; m++) begin
      p = 6'($urandom);
      pattern <= p;
      drive <= m[0];
      man = 5'($urandom);
      sc = 5'($urandom);
      scan_chan <= sc;
      wr(`IAD_MANUAL_OFS, {27'h0, man});
      ctl(2'(m), 1'b0, 1'b0);
      repeat (2) @(posedge pclk);
      rd(`IAD_DIN_OFS, "din", {27'h0, m[0] ? p : 6'h3f});
      rs();
    end
    // Every source against both thresholds at and beyond the limits
    ctl(2'h1, 1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      cfg(0, 1'b1, 1'b0, 1'b0, 2'(s));
      for (int k = 0; k < 4; k++) begin
        strobe(0, vals[k]);
        rs();
      end
    end
    // Latching input B on random thresholds, routed to the relays
    cfg(1, 1'b1, 1'b1, 1'b1, 2'h2);
    t = $urandom_range(5000, 100);
    hit[1] = t;
    lot[1] = -t;
    wr(ad(1, 2), t);
    wr(ad(1, 1), -t);
    rd(ad(1, 2), "high", {1'b0, hit[1]});
    strobe(1, t + 1);
    rs();
    strobe(1, -t - 1);
    ctl(2'h1, 1'b0, 1'b1);
    rs();
    strobe(1, 0);
    rs();
    ctl(2'h1, 1'b1, 1'b0);
    rs();
    ctl(2'h1, 1'b1, 1'b1);
    rs();
    // Optional inputs: absent, then installed and routed, and one disabled
    strobe(3, 2000);
    rs();
    cfg(3, 1'b1, 1'b0, 1'b1, 2'h0);
    strobe(3, 2000);
    rs();
    opt_installed <= 2'h2;
    strobe(3, 2000);
    strobe(2, 2000);
    rs();
    cfg(3, 1'b0, 1'b0, 1'b1, 2'h0);
    rs();
    // A frozen block ignores a strobe that would raise A's high alarm
    ce <= 1'b0;
    @(posedge pclk);
    reading[0] <= {4{32'sd2000}};
    reading_valid[0] <= 1'b1;
    @(posedge pclk);
    reading_valid[0] <= 1'b0;
    ce <= 1'b1;
    rs();
    repeat (2) @(posedge pclk);
    if (exp_q.size() != 0) begin
      mismatches++;
    end
    close_out();
  end
endmodule

`default_nettype wire
